// ---- ubs_regs.svh ----
// Purpose: Constants for receive break and FIFO error status logic
// Assumes: Status bit positions as used by the status word output
// Notes:   Definitions only
`ifndef UBS_REGS_SVH
`define UBS_REGS_SVH

`define UBS_BIT_BREAK_START   3
`define UBS_BIT_BREAK_END     4
`define UBS_BIT_FIFO_ERROR    5
`define UBS_STATUS_WIDTH      6
`define UBS_BOTTOM_ENTRIES    4
`define UBS_ERR_WIDTH         3

`endif

// ---- ubs_pkg.sv ----
// Purpose: Types for receive break and FIFO error status logic
// Assumes: Constants header included
// Notes:   Types only
`include "ubs_regs.svh"

package ubs_pkg;

   typedef logic [`UBS_ERR_WIDTH-1:0] ubs_err_t;
   typedef logic [`UBS_STATUS_WIDTH-1:0] ubs_status_t;

endpackage : ubs_pkg

// ---- ubs_break_status.sv ----
// Purpose: Break start/end detection, single null store, FIFO error flag
// Assumes: Character strobe and its flags come from the same clock domain
// Notes:   Receive pin is synchronised here before edge detection
//
// Operation
// (RULE_01) Null zero-parity zero-stop sets break start
// (RULE_02) During break store only first null
// (RULE_03) Break end only after break start
// (RULE_04) Rising receive edge sets break end
// (RULE_05) Break end re-arms start, reopens storing
// (RULE_06) Bottom-four entry error sets FIFO error
// (RULE_07) FIFO error blocks receive DMA requests
// (RULE_08) FIFO error follows entries, unwritable
// (RULE_09) Break flags hold until software clears
`timescale 1ns/1ps
`default_nettype none
`include "ubs_regs.svh"

module ubs_break_status
   import ubs_pkg::*;
(
   input  wire logic        clock_i,
   input  wire logic        rstn_i,
   input  wire logic        rx_pin_i,
   input  wire logic        char_valid_i,
   input  wire logic [7:0]  char_data_i,
   input  wire logic        char_parity_err_i,
   input  wire logic        char_frame_err_i,
   input  wire logic        char_is_null_break_i,
   input  wire logic [11:0] bottom_err_i,
   input  wire logic        dma_req_raw_i,
   input  wire logic        clr_break_start_i,
   input  wire logic        clr_break_end_i,
   output logic             fifo_write_o,
   output logic             dma_req_o,
   output logic             irq_o,
   output ubs_status_t      status_o
);

   // ****************************************************************
   // Receive pin synchroniser and edge
   // ****************************************************************
   logic sync1_reg, sync2_reg, sync3_reg;
   logic sync1_next, sync2_next, sync3_next;
   logic rx_rise;

   always_comb begin
      sync1_next = rx_pin_i;
      sync2_next = sync1_reg;
      sync3_next = sync2_reg;
   end

   always_ff @(posedge clock_i) begin
      if (!rstn_i) begin
         sync1_reg <= 1'b1;
         sync2_reg <= 1'b1;
         sync3_reg <= 1'b1;
      end else begin
         sync1_reg <= sync1_next;
         sync2_reg <= sync2_next;
         sync3_reg <= sync3_next;
      end
   end

   assign rx_rise = sync2_reg & ~sync3_reg;

   // ****************************************************************
   // Break flags
   // ****************************************************************
   logic break_start_flag_reg, break_start_flag_next;
   logic break_end_flag_reg, break_end_flag_next;
   logic armed_end_reg, armed_end_next;
   logic null_seen_reg, null_seen_next;
   logic null_break;
   logic start_evt, end_evt;

   // Null byte whose parity and stop both read zero
   assign null_break = char_valid_i & (char_data_i == 8'h00) & char_is_null_break_i
                       & char_frame_err_i;
   // Interlock: start only when not waiting for end
   assign start_evt = null_break & ~armed_end_reg;                          // RULE_01
   assign end_evt   = rx_rise & armed_end_reg;                              // RULE_03 RULE_04

   always_comb begin
      break_start_flag_next = break_start_flag_reg;
      break_end_flag_next   = break_end_flag_reg;
      armed_end_next        = armed_end_reg;
      null_seen_next        = null_seen_reg;
      if (clr_break_start_i) begin
         break_start_flag_next = 1'b0;                                      // RULE_09
      end
      if (clr_break_end_i) begin
         break_end_flag_next = 1'b0;                                        // RULE_09
      end
      // Set wins over a clear in the same cycle
      if (start_evt) begin
         break_start_flag_next = 1'b1;                                      // RULE_01
         armed_end_next        = 1'b1;
         // Starting null already went in, so every later null must drop
         null_seen_next        = 1'b1;                                      // RULE_02
      end
      if (null_break && armed_end_reg) begin
         null_seen_next = 1'b1;                                             // RULE_02
      end
      if (end_evt) begin
         break_end_flag_next = 1'b1;                                        // RULE_04
         armed_end_next      = 1'b0;                                        // RULE_05
         null_seen_next      = 1'b0;                                        // RULE_05
      end
   end

   always_ff @(posedge clock_i) begin
      if (!rstn_i) begin
         break_start_flag_reg <= 1'b0;
         break_end_flag_reg   <= 1'b0;
         armed_end_reg        <= 1'b0;
         null_seen_reg        <= 1'b0;
      end else begin
         break_start_flag_reg <= break_start_flag_next;
         break_end_flag_reg   <= break_end_flag_next;
         armed_end_reg        <= armed_end_next;
         null_seen_reg        <= null_seen_next;
      end
   end

   // ****************************************************************
   // FIFO write gate
   // ****************************************************************
   // First null of a break goes in; the rest of the break is dropped
   always_comb begin
      fifo_write_o = char_valid_i & ~(armed_end_reg & (null_seen_reg | ~null_break)); // RULE_02
   end

   // ****************************************************************
   // FIFO error flag
   // ****************************************************************
   logic [`UBS_BOTTOM_ENTRIES-1:0] entry_err;
   logic                           fifo_error_flag_reg, fifo_error_flag_next;

   genvar gi;
   generate
      for (gi = 0; gi < `UBS_BOTTOM_ENTRIES; gi++) begin : g_entry
         assign entry_err[gi] = |bottom_err_i[gi*`UBS_ERR_WIDTH +: `UBS_ERR_WIDTH]; // RULE_06
      end
   endgenerate

   // No software path reaches this flag
   always_comb begin
      fifo_error_flag_next = |entry_err;                                    // RULE_08
   end

   always_ff @(posedge clock_i) begin
      if (!rstn_i) begin
         fifo_error_flag_reg <= 1'b0;
      end else begin
         fifo_error_flag_reg <= fifo_error_flag_next;
      end
   end

   assign dma_req_o = dma_req_raw_i & ~fifo_error_flag_reg;                 // RULE_07
   assign irq_o     = break_start_flag_reg | break_end_flag_reg | fifo_error_flag_reg;

   always_comb begin
      status_o                     = '0;
      status_o[`UBS_BIT_BREAK_START] = break_start_flag_reg;
      status_o[`UBS_BIT_BREAK_END]   = break_end_flag_reg;
      status_o[`UBS_BIT_FIFO_ERROR]  = fifo_error_flag_reg;
   end

   // ****************************************************************
   // Checks
   // ****************************************************************
   sequence start_seen_s;
      start_evt;
   endsequence

   sequence flag_up_s;
      break_start_flag_reg & armed_end_reg;
   endsequence

   property start_sets_p;
      @(posedge clock_i) disable iff (!rstn_i) start_seen_s |=> flag_up_s;
   endproperty

   start_sets_a: assert property (start_sets_p)                             // RULE_01
      else $error("break start not flagged");

   second_null_drop_a: assert property (@(posedge clock_i) disable iff (!rstn_i) // RULE_02
      (null_break && armed_end_reg && null_seen_reg) |-> !fifo_write_o)
      else $error("repeated null stored during break");

   end_needs_start_a: assert property (@(posedge clock_i) disable iff (!rstn_i) // RULE_03
      $rose(break_end_flag_reg) |-> $past(armed_end_reg))
      else $error("break end without break start");

   end_on_rise_a: assert property (@(posedge clock_i) disable iff (!rstn_i) // RULE_04
      (rx_rise && armed_end_reg) |=> (break_end_flag_reg && !armed_end_reg))
      else $error("break end not flagged on rising edge");

   rearm_store_a: assert property (@(posedge clock_i) disable iff (!rstn_i) // RULE_05
      end_evt |=> (!null_seen_reg && (!char_valid_i || fifo_write_o)))
      else $error("storing not reopened after break end");

   fifo_err_a: assert property (@(posedge clock_i) disable iff (!rstn_i) // RULE_06
      (|bottom_err_i) |=> (fifo_error_flag_reg && irq_o))
      else $error("fifo error not flagged");

   dma_block_a: assert property (@(posedge clock_i) disable iff (!rstn_i) // RULE_07
      fifo_error_flag_reg |-> !dma_req_o)
      else $error("dma request while fifo error");

   fifo_err_follow_a: assert property (@(posedge clock_i) disable iff (!rstn_i) // RULE_08
      fifo_error_flag_reg == $past(|bottom_err_i))
      else $error("fifo error does not follow entries");

   flag_hold_a: assert property (@(posedge clock_i) disable iff (!rstn_i) // RULE_09
      (break_start_flag_reg && !clr_break_start_i) |=> break_start_flag_reg)
      else $error("break start dropped without clear");

endmodule : ubs_break_status

`default_nettype wire

// ---- ubs_line_model.sv ----
// Purpose: Remote transmitter side of the receive pin
// Assumes: Line has a pull-up, so idle reads high
// Notes:   Break is the line held low by the remote end
`timescale 1ns/1ps
`default_nettype none

module ubs_line_model (
   input  wire logic clock_i,
   input  wire logic hold_low_i,
   output logic      rx_o
);
   // Released line goes to the pull-up level, never keeps a stale low
   always_ff @(posedge clock_i) begin
      rx_o <= ~hold_low_i;
   end
endmodule : ubs_line_model

`default_nettype wire

// ---- ubs_break_status_test.sv ----
// Purpose: Self-checking bench for break and FIFO error status
// Assumes: Partner model drives the receive pin
// Notes:   Checks sampled 1 ns after the edge
`timescale 1ns/1ps
`default_nettype none
`include "ubs_regs.svh"

module ubs_break_status_test;
   import ubs_pkg::*;
   logic clock_i, rstn_i, rx_pin_i, hold_low, char_valid_i, char_parity_err_i;
   logic char_frame_err_i, char_is_null_break_i, dma_req_raw_i;
   logic clr_break_start_i, clr_break_end_i, fifo_write_o, dma_req_o, irq_o;
   logic [7:0]  char_data_i;
   logic [11:0] bottom_err_i;
   ubs_status_t status_o;
   int errors = 0;
   int checks_done = 0;

   ubs_line_model line (.clock_i(clock_i), .hold_low_i(hold_low), .rx_o(rx_pin_i));
   ubs_break_status uut (.clock_i(clock_i), .rstn_i(rstn_i), .rx_pin_i(rx_pin_i),
      .char_valid_i(char_valid_i), .char_data_i(char_data_i),
      .char_parity_err_i(char_parity_err_i), .char_frame_err_i(char_frame_err_i),
      .char_is_null_break_i(char_is_null_break_i), .bottom_err_i(bottom_err_i),
      .dma_req_raw_i(dma_req_raw_i), .clr_break_start_i(clr_break_start_i),
      .clr_break_end_i(clr_break_end_i), .fifo_write_o(fifo_write_o),
      .dma_req_o(dma_req_o), .irq_o(irq_o), .status_o(status_o));

   initial begin
      clock_i = 1'b0;
      forever #2.5 clock_i = ~clock_i;
   end

   task give_verdict;
      $display("checks %0d, errors %0d", checks_done, errors);
      if (errors == 0 && checks_done > 0) $display("== PASSED ==");
      else $display("== FAILED ==");
      $finish;
   endtask : give_verdict

   task chk(input string what, input logic seen, input logic exp);
      checks_done++;
      if (seen !== exp) begin
         errors++;
         $display("wrong value %s expected %b seen %b", what, exp, seen);
      end
   endtask : chk

   task idle;
      @(posedge clock_i);
      char_valid_i      <= 1'b0;
      clr_break_start_i <= 1'b0;
      clr_break_end_i   <= 1'b0;
      #1;
   endtask : idle

   task send(input logic [7:0] d, input logic fe, input logic nb);
      @(posedge clock_i);
      char_valid_i <= 1'b1;
      char_data_i <= d;
      char_frame_err_i <= fe;
      char_is_null_break_i <= nb;
      #1;
   endtask : send

   task rise_line(input logic expect_end);
      int n;
      @(posedge clock_i);
      hold_low <= 1'b0;
      for (n = 0; n < 10 && status_o[`UBS_BIT_BREAK_END] !== 1'b1; n++) idle();
      if (expect_end && n == 10) begin
         errors++;
         give_verdict();
      end
      chk("break end", status_o[`UBS_BIT_BREAK_END], expect_end);
   endtask : rise_line

   task t_break;
      hold_low <= 1'b1;
      rise_line(1'b0);
      hold_low <= 1'b1;
      send(8'h00, 1'b1, 1'b1);
      chk("first null write", fifo_write_o, 1'b1);
      idle();
      chk("break start", status_o[`UBS_BIT_BREAK_START], 1'b1);
      chk("irq start", irq_o, 1'b1);
      send(8'h00, 1'b1, 1'b1);
      chk("second null write", fifo_write_o, 1'b0);
      idle();
      rise_line(1'b1);
      send(8'h41, 1'b0, 1'b0);
      chk("char after end", fifo_write_o, 1'b1);
      idle();
      chk("start held", status_o[`UBS_BIT_BREAK_START], 1'b1);
   endtask : t_break

   task t_clear;
      @(posedge clock_i);
      clr_break_start_i <= 1'b1;
      clr_break_end_i <= 1'b1;
      idle();
      idle();
      chk("flags cleared", |status_o, 1'b0);
      chk("irq cleared", irq_o, 1'b0);
      send(8'h00, 1'b1, 1'b1);
      idle();
      chk("rearmed start", status_o[`UBS_BIT_BREAK_START], 1'b1);
   endtask : t_clear

   task t_fifo_err;
      // Drop the leftover break start so the interrupt shows only the error flag
      @(posedge clock_i);
      clr_break_start_i <= 1'b1;
      idle();
      for (int e = 0; e < 12; e++) begin
         @(posedge clock_i);
         bottom_err_i <= 12'h001 << e;
         dma_req_raw_i <= 1'b1;
         idle();
         chk("fifo error", status_o[`UBS_BIT_FIFO_ERROR], 1'b1);
         chk("dma blocked", dma_req_o, 1'b0);
         chk("irq error", irq_o, 1'b1);
         @(posedge clock_i);
         bottom_err_i <= 12'h000;
         idle();
         chk("error follows", status_o[`UBS_BIT_FIFO_ERROR], 1'b0);
         chk("dma reopened", dma_req_o, 1'b1);
         chk("irq follows", irq_o, 1'b0);
      end
   endtask : t_fifo_err

   initial begin
      {rstn_i, hold_low, char_valid_i, char_parity_err_i, char_frame_err_i} = '0;
      {char_is_null_break_i, dma_req_raw_i, clr_break_start_i, clr_break_end_i} = '0;
      char_data_i = 8'h00;
      bottom_err_i = 12'h000;
      repeat (4) @(posedge clock_i);
      rstn_i <= 1'b1;
      idle();
      t_break();
      t_clear();
      t_fifo_err();
      give_verdict();
   end
endmodule : ubs_break_status_test

`default_nettype wire
